// ===== src/rlc_pkg.sv
// Constants, types and register map of the receiver listen / calibration / low-battery slice.
// Assumes a single 100 MHz clock and a plain byte-wide register port.
package rlc_pkg;

  localparam logic [7:0] RLC_OFS_FRF_LOW = 8'h09;
  localparam logic [7:0] RLC_OFS_OSC = 8'h0A;
  localparam logic [7:0] RLC_OFS_AFC = 8'h0B;
  localparam logic [7:0] RLC_OFS_LOWBAT = 8'h0C;
  localparam logic [7:0] RLC_OFS_LISTEN1 = 8'h0D;
  localparam logic [7:0] RLC_OFS_IDLE_COEF = 8'h0E;
  localparam logic [7:0] RLC_OFS_RX_COEF = 8'h0F;
  localparam logic [7:0] RLC_OFS_IRQ_STAT = 8'h60;
  localparam logic [7:0] RLC_OFS_IRQ_MASK = 8'h61;

  localparam logic [7:0] RLC_RST_FRF_LOW = 8'h00;
  localparam logic RLC_RST_AFC_SEL = 1'b0;
  localparam logic RLC_RST_BATT_EN = 1'b0;
  localparam logic [2:0] RLC_RST_TRIM = 3'h2;
  localparam logic [1:0] RLC_RST_IDLE_UNIT = 2'h2;
  localparam logic [1:0] RLC_RST_RX_UNIT = 2'h1;
  localparam logic RLC_RST_CRIT = 1'b0;
  localparam logic [1:0] RLC_RST_EXIT = 2'h1;
  localparam logic [7:0] RLC_RST_IDLE_COEF = 8'hF5;
  localparam logic [7:0] RLC_RST_RX_COEF = 8'h20;

  localparam int RLC_BIT_CAL_TRIG = 7;
  localparam int RLC_BIT_CAL_DONE = 6;
  localparam int RLC_BIT_AFC_SEL = 5;
  localparam int RLC_BIT_BATT_LIVE = 4;
  localparam int RLC_BIT_BATT_EN = 3;
  localparam logic [5:0] RLC_OSC_FIXED = 6'h01;

  localparam logic [1:0] RLC_EXIT_STAY = 2'h0;
  localparam logic [1:0] RLC_EXIT_MODE = 2'h1;
  localparam logic [1:0] RLC_EXIT_RESUME = 2'h2;

  localparam logic [2:0] RLC_MODE_SLEEP = 3'h0;
  localparam logic [2:0] RLC_MODE_STANDBY = 3'h1;
  localparam logic [2:0] RLC_MODE_SYNTH = 3'h2;
  localparam logic [2:0] RLC_MODE_RX = 3'h4;

  localparam int RLC_CLK_PERIOD_NS = 10;
  localparam int RLC_UNIT_A_US = 64;
  localparam int RLC_UNIT_B_US = 4100;
  localparam int RLC_UNIT_C_US = 262000;
  localparam int RLC_UNIT_A_CYC = RLC_UNIT_A_US * 1000 / RLC_CLK_PERIOD_NS;
  localparam int RLC_UNIT_B_CYC = RLC_UNIT_B_US * 1000 / RLC_CLK_PERIOD_NS;
  localparam int RLC_UNIT_C_CYC = RLC_UNIT_C_US * 1000 / RLC_CLK_PERIOD_NS;
  localparam int RLC_CAL_CYCLES = 64;

  localparam int RLC_IRQ_CAL = 0;
  localparam int RLC_IRQ_ACCEPT = 1;
  localparam int RLC_IRQ_BATT = 2;

  typedef enum logic [2:0] {
    RLC_L_OFF, RLC_L_IDLE, RLC_L_RX, RLC_L_HOLD, RLC_L_STOP
  } rlc_listen_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rlc_bus_req_t;

endpackage

// ===== src/rlc_regs.sv
// Register slice 0x09..0x0F of a UHF receiver: carrier low byte, RC calibration, AFC select,
// low-battery detector and listen-mode sequencing, plus a small interrupt block.
// Assumes synchronous inputs from the mode register, demodulator, packet engine and comparator.
//
// Operation
// - Register holds carrier word bits 7..0, reset zero; full word times step.
// - Writing one to bit 7 starts RC calibration; bit reads zero.
// - Done flag at bit 6 is zero while calibrating, one otherwise; resets one.
// - Bit 5 selects standard AFC at zero, improved low-index AFC at one.
// - Bit 4 shows the live low-battery comparator while the detector is on.
// - Bit 3 switches the low-battery detector on; resets off.
// - Bits 2..0 pick one of eight battery thresholds; reset code 010.
// - Idle time unit bits 7..6: 64 us, 4.1 ms, 262 ms; reset 10.
// - Receive time unit bits 5..4: 64 us, 4.1 ms, 262 ms; reset 01.
// - Acceptance needs signal level alone, or level plus sync match when set.
// - Exit code 00: stay in receive after acceptance, listening stops.
// - Exit code 01: receive until payload or timeout, then programmed mode.
// - Exit code 10: receive until payload or timeout, resume idle, flush FIFO.
// - Idle phase lasts idle coefficient times idle unit.
// - Receive phase lasts receive coefficient times receive unit.
// - Mode codes: sleep 000, standby 001, synthesizer 010, receive 100.
`timescale 1ns/100ps
`default_nettype none

module rlc_regs
  import rlc_pkg::*;
#(
  parameter int UNIT_A_CYC = RLC_UNIT_A_CYC,
  parameter int UNIT_B_CYC = RLC_UNIT_B_CYC,
  parameter int UNIT_C_CYC = RLC_UNIT_C_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire rlc_bus_req_t bus,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] op_mode_field,
  input wire logic listen_enable,
  input wire logic batt_comparator,
  input wire logic signal_level_threshold,
  input wire logic sync_and_node_match,
  input wire logic payload_complete_event,
  input wire logic rx_timeout_event,
  output logic [7:0] carrier_word_low,
  output logic afc_low_index_select,
  output logic batt_detector_enable,
  output logic [2:0] batt_threshold_trim,
  output logic rc_calib_running,
  output logic [2:0] chip_mode,
  output logic fifo_flush,
  output logic irq
);

  localparam int CAL_WAIT = RLC_CAL_CYCLES;

  typedef struct packed {
    logic [7:0] frf_low;
    logic afc_sel;
    logic batt_en;
    logic [2:0] trim;
    logic [1:0] idle_unit;
    logic [1:0] rx_unit;
    logic crit;
    logic [1:0] exit_act;
    logic [7:0] idle_coef;
    logic [7:0] rx_coef;
    logic cal_busy;
    logic [15:0] cal_cnt;
    rlc_listen_t lst;
    logic [31:0] tick;
    logic [7:0] units;
    logic [2:0] mode_out;
    logic flush_pend;
    logic flush;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic batt_prev;
    logic [7:0] rdata;
  } rlc_state_t;

  rlc_state_t r;
  rlc_state_t next_r;

  // Reserved codes fall back to the shortest unit so a phase never stalls
  function automatic logic [31:0] unit_cycles(input logic [1:0] code);
    case (code)
      2'h2: unit_cycles = 32'(UNIT_B_CYC);
      2'h3: unit_cycles = 32'(UNIT_C_CYC);
      default: unit_cycles = 32'(UNIT_A_CYC);
    endcase
  endfunction

  function automatic logic hit(input rlc_bus_req_t b, input logic [7:0] ofs);
    hit = (b.addr == ofs);
  endfunction

  logic batt_live;
  logic accept;
  logic hold_done;
  logic cal_start;
  logic cal_end;
  logic [31:0] cur_unit;
  logic [7:0] cur_coef;
  logic unit_wrap;
  logic phase_over;

  always_comb begin
    batt_live = r.batt_en & batt_comparator;
    accept = signal_level_threshold & (~r.crit | sync_and_node_match);
    hold_done = payload_complete_event | rx_timeout_event;
    cal_start = bus.wr & hit(bus, RLC_OFS_OSC) & bus.wdata[RLC_BIT_CAL_TRIG];
    cal_end = r.cal_busy & (r.cal_cnt == 16'(CAL_WAIT - 1));
    cur_unit = (r.lst == RLC_L_IDLE) ? unit_cycles(r.idle_unit) : unit_cycles(r.rx_unit);
    cur_coef = (r.lst == RLC_L_IDLE) ? r.idle_coef : r.rx_coef;
    unit_wrap = (r.tick == cur_unit - 32'h1);
    // The phase ends on the last cycle of its last unit; coefficient zero still gives one cycle
    phase_over = (cur_coef == 8'h00) ||
                 (unit_wrap && (r.units + 8'h01 == cur_coef));
  end

  always_comb begin
    next_r = r;
    next_r.flush = 1'b0;
    next_r.batt_prev = batt_live;

    if (bus.wr) begin
      if (hit(bus, RLC_OFS_FRF_LOW)) begin
        next_r.frf_low = bus.wdata;
      end
      if (hit(bus, RLC_OFS_AFC)) begin
        next_r.afc_sel = bus.wdata[RLC_BIT_AFC_SEL];
      end
      if (hit(bus, RLC_OFS_LOWBAT)) begin
        next_r.batt_en = bus.wdata[RLC_BIT_BATT_EN];
        next_r.trim = bus.wdata[2:0];
      end
      if (hit(bus, RLC_OFS_LISTEN1)) begin
        next_r.idle_unit = bus.wdata[7:6];
        next_r.rx_unit = bus.wdata[5:4];
        next_r.crit = bus.wdata[3];
        next_r.exit_act = bus.wdata[2:1];
      end
      if (hit(bus, RLC_OFS_IDLE_COEF)) begin
        next_r.idle_coef = bus.wdata;
      end
      if (hit(bus, RLC_OFS_RX_COEF)) begin
        next_r.rx_coef = bus.wdata;
      end
      if (hit(bus, RLC_OFS_IRQ_MASK)) begin
        next_r.irq_mask = bus.wdata[2:0];
      end
    end

    // Calibration is started regardless of mode; standby is software's duty
    if (cal_start) begin
      next_r.cal_busy = 1'b1;
      next_r.cal_cnt = 16'h0000;
    end else if (cal_end) begin
      next_r.cal_busy = 1'b0;
    end else if (r.cal_busy) begin
      next_r.cal_cnt = r.cal_cnt + 16'h0001;
    end

    if (unit_wrap) begin
      next_r.tick = 32'h0;
      next_r.units = r.units + 8'h01;
    end else begin
      next_r.tick = r.tick + 32'h1;
    end

    case (r.lst)
      RLC_L_OFF: begin
        next_r.mode_out = op_mode_field;
        next_r.tick = 32'h0;
        next_r.units = 8'h00;
        // Enabling outside standby is not guarded here
        if (listen_enable) begin
          next_r.lst = RLC_L_IDLE;
          next_r.mode_out = RLC_MODE_SLEEP;
        end
      end
      RLC_L_IDLE: begin
        next_r.mode_out = RLC_MODE_SLEEP;
        if (phase_over) begin
          next_r.lst = RLC_L_RX;
          next_r.mode_out = RLC_MODE_RX;
          next_r.tick = 32'h0;
          next_r.units = 8'h00;
          if (r.flush_pend) begin
            next_r.flush = 1'b1;
            next_r.flush_pend = 1'b0;
          end
        end
      end
      RLC_L_RX: begin
        next_r.mode_out = RLC_MODE_RX;
        if (accept) begin
          if (r.exit_act == RLC_EXIT_MODE || r.exit_act == RLC_EXIT_RESUME) begin
            next_r.lst = RLC_L_HOLD;
          end else begin
            next_r.lst = RLC_L_STOP;
          end
        end else if (phase_over) begin
          next_r.lst = RLC_L_IDLE;
          next_r.mode_out = RLC_MODE_SLEEP;
          next_r.tick = 32'h0;
          next_r.units = 8'h00;
        end
      end
      RLC_L_HOLD: begin
        if (hold_done) begin
          if (r.exit_act == RLC_EXIT_RESUME) begin
            next_r.lst = RLC_L_IDLE;
            next_r.mode_out = RLC_MODE_SLEEP;
            next_r.flush_pend = 1'b1;
            next_r.tick = 32'h0;
            next_r.units = 8'h00;
          end else begin
            next_r.lst = RLC_L_STOP;
            next_r.mode_out = op_mode_field;
          end
        end
      end
      RLC_L_STOP: begin
        // Held until software drops the enable
      end
      default: begin
        next_r.lst = RLC_L_OFF;
      end
    endcase

    if (!listen_enable) begin
      next_r.lst = RLC_L_OFF;
      next_r.mode_out = op_mode_field;
      next_r.flush_pend = 1'b0;
    end

    next_r.rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        RLC_OFS_FRF_LOW: next_r.rdata = r.frf_low;
        RLC_OFS_OSC: next_r.rdata = {1'b0, ~r.cal_busy, RLC_OSC_FIXED};
        RLC_OFS_AFC: next_r.rdata = {2'b00, r.afc_sel, 5'b00000};
        RLC_OFS_LOWBAT: next_r.rdata = {3'b000, batt_live, r.batt_en, r.trim};
        RLC_OFS_LISTEN1: next_r.rdata = {r.idle_unit, r.rx_unit, r.crit, r.exit_act, 1'b0};
        RLC_OFS_IDLE_COEF: next_r.rdata = r.idle_coef;
        RLC_OFS_RX_COEF: next_r.rdata = r.rx_coef;
        RLC_OFS_IRQ_STAT: next_r.rdata = {5'b00000, r.irq_stat};
        RLC_OFS_IRQ_MASK: next_r.rdata = {5'b00000, r.irq_mask};
        default: next_r.rdata = 8'h00;
      endcase
    end

    // Read clears status, but a same-cycle event survives the clear
    if (bus.rd && hit(bus, RLC_OFS_IRQ_STAT)) begin
      next_r.irq_stat = 3'b000;
    end
    next_r.irq_stat[RLC_IRQ_CAL] = next_r.irq_stat[RLC_IRQ_CAL] | cal_end;
    next_r.irq_stat[RLC_IRQ_ACCEPT] = next_r.irq_stat[RLC_IRQ_ACCEPT] |
                                      ((r.lst == RLC_L_RX) & accept & listen_enable);
    next_r.irq_stat[RLC_IRQ_BATT] = next_r.irq_stat[RLC_IRQ_BATT] | (batt_live & ~r.batt_prev);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
      r.frf_low <= RLC_RST_FRF_LOW;
      r.afc_sel <= RLC_RST_AFC_SEL;
      r.batt_en <= RLC_RST_BATT_EN;
      r.trim <= RLC_RST_TRIM;
      r.idle_unit <= RLC_RST_IDLE_UNIT;
      r.rx_unit <= RLC_RST_RX_UNIT;
      r.crit <= RLC_RST_CRIT;
      r.exit_act <= RLC_RST_EXIT;
      r.idle_coef <= RLC_RST_IDLE_COEF;
      r.rx_coef <= RLC_RST_RX_COEF;
      r.lst <= RLC_L_OFF;
      r.mode_out <= RLC_MODE_STANDBY;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata = r.rdata;
  assign carrier_word_low = r.frf_low;
  assign afc_low_index_select = r.afc_sel;
  assign batt_detector_enable = r.batt_en;
  assign batt_threshold_trim = r.trim;
  assign rc_calib_running = r.cal_busy;
  assign chip_mode = r.mode_out;
  assign fifo_flush = r.flush;
  assign irq = |(r.irq_stat & r.irq_mask);

  a_frf_readback: assert property (@(posedge clk) disable iff (!rst_b)
    (bus.rd && bus.addr == RLC_OFS_FRF_LOW) |=> reg_rdata == $past(r.frf_low))
    else $error("carrier low byte read mismatch");

  a_trig_reads_zero: assert property (@(posedge clk) disable iff (!rst_b)
    (bus.rd && bus.addr == RLC_OFS_OSC) |=> reg_rdata[7] == 1'b0 && reg_rdata[5:0] == 6'h01)
    else $error("calibration register read wrong");

  a_cal_finishes: assert property (@(posedge clk) disable iff (!rst_b)
    (cal_start && !r.cal_busy) |=> rc_calib_running ##[1:CAL_WAIT] !rc_calib_running)
    else $error("calibration did not finish in time");

  a_done_flag: assert property (@(posedge clk) disable iff (!rst_b)
    (bus.rd && bus.addr == RLC_OFS_OSC) |=> reg_rdata[6] == !$past(r.cal_busy))
    else $error("calibration done flag wrong");

  a_batt_live: assert property (@(posedge clk) disable iff (!rst_b)
    (bus.rd && bus.addr == RLC_OFS_LOWBAT) |=>
      reg_rdata[4] == $past(batt_comparator & batt_detector_enable) && reg_rdata[7:5] == 3'h0)
    else $error("low battery live bit wrong");

  a_rx_mode_code: assert property (@(posedge clk) disable iff (!rst_b)
    (r.lst == RLC_L_RX) |-> chip_mode == RLC_MODE_RX)
    else $error("receive phase without receive mode");

  a_exit_stay: assert property (@(posedge clk) disable iff (!rst_b)
    (r.lst == RLC_L_RX && accept && listen_enable && r.exit_act == RLC_EXIT_STAY) |=>
      (r.lst == RLC_L_STOP && chip_mode == RLC_MODE_RX))
    else $error("exit code 00 did not stay in receive");

  a_exit_mode: assert property (@(posedge clk) disable iff (!rst_b)
    (r.lst == RLC_L_HOLD && hold_done && listen_enable && r.exit_act == RLC_EXIT_MODE) |=>
      (r.lst == RLC_L_STOP && chip_mode == $past(op_mode_field)))
    else $error("exit code 01 did not enter programmed mode");

  a_exit_resume: assert property (@(posedge clk) disable iff (!rst_b)
    (r.lst == RLC_L_HOLD && hold_done && listen_enable && r.exit_act == RLC_EXIT_RESUME) |=>
      (r.lst == RLC_L_IDLE && r.flush_pend))
    else $error("exit code 10 did not resume idle");

  a_sync_needed: assert property (@(posedge clk) disable iff (!rst_b)
    (r.lst == RLC_L_RX && r.crit && !sync_and_node_match) |=>
      !(r.lst inside {RLC_L_HOLD, RLC_L_STOP}))
    else $error("packet accepted without sync match");

  a_idle_len: assert property (@(posedge clk) disable iff (!rst_b)
    (r.lst == RLC_L_IDLE && listen_enable && (r.idle_coef == 8'h00 ||
      (r.units == r.idle_coef - 8'h01 && r.tick == unit_cycles(r.idle_unit) - 32'h1))) |=>
      r.lst == RLC_L_RX)
    else $error("idle phase length wrong");

  a_rx_len: assert property (@(posedge clk) disable iff (!rst_b)
    (r.lst == RLC_L_RX && !accept && listen_enable && (r.rx_coef == 8'h00 ||
      (r.units == r.rx_coef - 8'h01 && r.tick == unit_cycles(r.rx_unit) - 32'h1))) |=>
      r.lst == RLC_L_IDLE)
    else $error("receive phase length wrong");

  a_frf_write: assert property (@(posedge clk) disable iff (!rst_b)
    (bus.wr && bus.addr == RLC_OFS_FRF_LOW) |=> carrier_word_low == $past(bus.wdata))
    else $error("carrier low byte write lost");

  a_cal_start: assert property (@(posedge clk) disable iff (!rst_b)
    (bus.wr && bus.addr == RLC_OFS_OSC && bus.wdata[7]) |=> rc_calib_running)
    else $error("calibration trigger ignored");

  a_afc_write: assert property (@(posedge clk) disable iff (!rst_b)
    (bus.wr && bus.addr == RLC_OFS_AFC) |=> afc_low_index_select == $past(bus.wdata[5]))
    else $error("AFC routine select write lost");

  a_batt_write: assert property (@(posedge clk) disable iff (!rst_b)
    (bus.wr && bus.addr == RLC_OFS_LOWBAT) |=>
      batt_detector_enable == $past(bus.wdata[3]) &&
      batt_threshold_trim == $past(bus.wdata[2:0]))
    else $error("low battery control write lost");

  a_listen_off: assert property (@(posedge clk) disable iff (!rst_b)
    !listen_enable |=> r.lst == RLC_L_OFF && chip_mode == $past(op_mode_field))
    else $error("listen mode did not stop when disabled");

  a_idle_sleep: assert property (@(posedge clk) disable iff (!rst_b)
    (r.lst == RLC_L_IDLE) |-> chip_mode == RLC_MODE_SLEEP)
    else $error("idle phase without sleep mode");

endmodule

`default_nettype wire

// ===== tb/test_rlc_regs.sv
// Self-checking bench for the receiver register slice: register map, calibration,
// battery monitor, interrupts and listen sequencing.
// Assumes the unit parameters are shrunk to 4, 8 and 16 cycles to keep the run short.
`timescale 1ns/100ps
`default_nettype none

module test_rlc_regs
  import rlc_pkg::*;
;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } rlc_row_t;

  logic clk;
  logic rst_b;
  rlc_bus_req_t bus;
  logic [7:0] reg_rdata;
  logic [2:0] op_mode_field;
  logic listen_enable;
  logic batt_comparator;
  logic signal_level_threshold;
  logic sync_and_node_match;
  logic payload_complete_event;
  logic rx_timeout_event;
  logic [7:0] carrier_word_low;
  logic afc_low_index_select;
  logic batt_detector_enable;
  logic [2:0] batt_threshold_trim;
  logic rc_calib_running;
  logic [2:0] chip_mode;
  logic fifo_flush;
  logic irq;
  int failures;
  int compares;
  int span;
  logic [7:0] rv;

  // Write value, then the value that must read back
  rlc_row_t rows [11] = '{
    '{8'h09, 8'hA5, 8'hA5}, '{8'h0A, 8'h3F, 8'h41}, '{8'h0B, 8'hFF, 8'h20},
    '{8'h0B, 8'h00, 8'h00}, '{8'h0C, 8'hFF, 8'h0F}, '{8'h0C, 8'h06, 8'h06},
    '{8'h0D, 8'hFF, 8'hFE}, '{8'h0D, 8'h52, 8'h52}, '{8'h0E, 8'h03, 8'h03},
    '{8'h0F, 8'h02, 8'h02}, '{8'h20, 8'hFF, 8'h00}};
  rlc_row_t rst_rows [7] = '{
    '{8'h09, 8'h00, 8'h00}, '{8'h0A, 8'h00, 8'h41}, '{8'h0B, 8'h00, 8'h00},
    '{8'h0C, 8'h00, 8'h02}, '{8'h0D, 8'h00, 8'h92}, '{8'h0E, 8'h00, 8'hF5},
    '{8'h0F, 8'h00, 8'h20}};

  rlc_regs #(.UNIT_A_CYC(4), .UNIT_B_CYC(8), .UNIT_C_CYC(16)) dut (
    .clk(clk), .rst_b(rst_b), .bus(bus), .reg_rdata(reg_rdata),
    .op_mode_field(op_mode_field), .listen_enable(listen_enable),
    .batt_comparator(batt_comparator), .signal_level_threshold(signal_level_threshold),
    .sync_and_node_match(sync_and_node_match),
    .payload_complete_event(payload_complete_event), .rx_timeout_event(rx_timeout_event),
    .carrier_word_low(carrier_word_low), .afc_low_index_select(afc_low_index_select),
    .batt_detector_enable(batt_detector_enable), .batt_threshold_trim(batt_threshold_trim),
    .rc_calib_running(rc_calib_running), .chip_mode(chip_mode), .fifo_flush(fifo_flush),
    .irq(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // A leading edge wait keeps two strobes from being assigned in one time step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    rv = reg_rdata;
  endtask

  task automatic wait_mode(input logic [2:0] m);
    span = 0;
    while (chip_mode !== m && span < 2000) begin
      @(posedge clk);
      #1;
      span++;
    end
    check({5'h0, chip_mode}, {5'h0, m});
  endtask

  task automatic pulse_accept();
    @(posedge clk);
    signal_level_threshold <= 1'b1;
    @(posedge clk);
    signal_level_threshold <= 1'b0;
  endtask

  task automatic conclude();
    $display("comparisons %0d, failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    failures++;
    conclude();
  end

  initial begin
    failures = 0;
    compares = 0;
    rst_b = 1'b0;
    bus = '0;
    op_mode_field = RLC_MODE_STANDBY;
    listen_enable = 1'b0;
    batt_comparator = 1'b0;
    signal_level_threshold = 1'b0;
    sync_and_node_match = 1'b0;
    payload_complete_event = 1'b0;
    rx_timeout_event = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a);
      check(rv, rows[i].e);
    end
    check(carrier_word_low, 8'hA5);
    check({7'h0, afc_low_index_select}, 8'h00);
    check({4'h0, batt_detector_enable, batt_threshold_trim}, 8'h06);
    // Second reset in mid-run brings every field back
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rst_rows[i]) begin
      rd_reg(rst_rows[i].a);
      check(rv, rst_rows[i].e);
    end
    // Calibration with its interrupt masked first; the chip sits in standby
    wr_reg(RLC_OFS_OSC, 8'h80);
    rd_reg(RLC_OFS_OSC);
    check(rv, 8'h01);
    check({7'h0, rc_calib_running}, 8'h01);
    repeat (70) @(posedge clk);
    rd_reg(RLC_OFS_OSC);
    check(rv, 8'h41);
    check({7'h0, rc_calib_running}, 8'h00);
    check({7'h0, irq}, 8'h00);
    wr_reg(RLC_OFS_IRQ_MASK, 8'h07);
    #1;
    check({7'h0, irq}, 8'h01);
    rd_reg(RLC_OFS_IRQ_STAT);
    check(rv, 8'h01);
    #1;
    check({7'h0, irq}, 8'h00);
    // Live battery bit follows the comparator without latching
    wr_reg(RLC_OFS_LOWBAT, 8'h0A);
    batt_comparator <= 1'b1;
    rd_reg(RLC_OFS_LOWBAT);
    check(rv, 8'h1A);
    @(posedge clk);
    batt_comparator <= 1'b0;
    rd_reg(RLC_OFS_LOWBAT);
    check(rv, 8'h0A);
    check({7'h0, irq}, 8'h01);
    rd_reg(RLC_OFS_IRQ_STAT);
    check(rv, 8'h04);
    wr_reg(RLC_OFS_LOWBAT, 8'h02);
    batt_comparator <= 1'b1;
    rd_reg(RLC_OFS_LOWBAT);
    check(rv, 8'h02);
    // Listen, exit code 10: hold receive, then resume with a flush
    wr_reg(RLC_OFS_IDLE_COEF, 8'h01);
    wr_reg(RLC_OFS_RX_COEF, 8'h01);
    wr_reg(RLC_OFS_LISTEN1, 8'h54);
    listen_enable <= 1'b1;
    wait_mode(RLC_MODE_SLEEP);
    wait_mode(RLC_MODE_RX);
    check(span[7:0], 8'h04);
    pulse_accept();
    repeat (10) @(posedge clk);
    #1;
    check({5'h0, chip_mode}, {5'h0, RLC_MODE_RX});
    @(posedge clk);
    payload_complete_event <= 1'b1;
    @(posedge clk);
    payload_complete_event <= 1'b0;
    wait_mode(RLC_MODE_SLEEP);
    wait_mode(RLC_MODE_RX);
    check({7'h0, fifo_flush}, 8'h01);
    @(posedge clk);
    listen_enable <= 1'b0;
    #1;
    check({7'h0, fifo_flush}, 8'h00);
    // Exit code 01: after timeout go to the mode field and stay there
    wait_mode(RLC_MODE_STANDBY);
    wr_reg(RLC_OFS_LISTEN1, 8'h52);
    listen_enable <= 1'b1;
    wait_mode(RLC_MODE_RX);
    pulse_accept();
    op_mode_field <= RLC_MODE_SYNTH;
    rx_timeout_event <= 1'b1;
    @(posedge clk);
    rx_timeout_event <= 1'b0;
    wait_mode(RLC_MODE_SYNTH);
    repeat (20) @(posedge clk);
    #1;
    check({5'h0, chip_mode}, {5'h0, RLC_MODE_SYNTH});
    // Exit code 00 with sync required: level alone is not enough
    @(posedge clk);
    listen_enable <= 1'b0;
    op_mode_field <= RLC_MODE_STANDBY;
    wait_mode(RLC_MODE_STANDBY);
    rd_reg(RLC_OFS_IRQ_STAT);
    check(rv, 8'h02);
    wr_reg(RLC_OFS_LISTEN1, 8'h58);
    signal_level_threshold <= 1'b1;
    listen_enable <= 1'b1;
    wait_mode(RLC_MODE_RX);
    wait_mode(RLC_MODE_SLEEP);
    check(span[7:0], 8'h04);
    check({7'h0, irq}, 8'h00);
    wait_mode(RLC_MODE_RX);
    @(posedge clk);
    sync_and_node_match <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    check({5'h0, chip_mode}, {5'h0, RLC_MODE_RX});
    rd_reg(RLC_OFS_IRQ_STAT);
    check(rv, 8'h02);
    // Longer units: idle code 11 and receive code 10, one unit each
    @(posedge clk);
    listen_enable <= 1'b0;
    signal_level_threshold <= 1'b0;
    sync_and_node_match <= 1'b0;
    wait_mode(RLC_MODE_STANDBY);
    wr_reg(RLC_OFS_LISTEN1, 8'hE2);
    listen_enable <= 1'b1;
    wait_mode(RLC_MODE_SLEEP);
    wait_mode(RLC_MODE_RX);
    check(span[7:0], 8'h10);
    wait_mode(RLC_MODE_SLEEP);
    check(span[7:0], 8'h08);
    @(posedge clk);
    listen_enable <= 1'b0;
    wait_mode(RLC_MODE_STANDBY);
    conclude();
  end
endmodule

`default_nettype wire
